// file: common/vic_regs.svh
// Register map and field positions of the vectored interrupt controller
// Assumes a 32-bit word-addressed Avalon-MM slave, word offsets below
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

`define VIC_OFF_CTRL0      4'h0
`define VIC_OFF_CTRL1      4'h1
`define VIC_OFF_TBCTRL     4'h2
`define VIC_OFF_EDGE       4'h3
`define VIC_OFF_PC         4'h4
`define VIC_OFF_STATUS     4'h5

`define VIC_BIT_GIE        0
`define VIC_BIT_PIN_EN     1
`define VIC_BIT_SER_EN     2
`define VIC_BIT_PIN_F      4
`define VIC_BIT_SER_F      5

`define VIC_BIT_CONV_EN    0
`define VIC_BIT_NV_EN      1
`define VIC_BIT_PER_EN     2
`define VIC_BIT_CMPA_EN    3
`define VIC_BIT_CONV_F     4
`define VIC_BIT_NV_F       5
`define VIC_BIT_PER_F      6
`define VIC_BIT_CMPA_F     7

`define VIC_BIT_TB0_EN     0
`define VIC_BIT_TB1_EN     1
`define VIC_BIT_TB0_F      4
`define VIC_BIT_TB1_F      5
`define VIC_TBCTRL_MASK    8'h33

`define VIC_CTRL0_MASK     8'h37
`define VIC_RST_BYTE       8'h00
`define VIC_VEC_BASE       12'h004
`define VIC_VEC_STEP       12'h004

`endif

// file: common/vic_pkg.sv
// Types shared by the interrupt controller files
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package vic_pkg;
  typedef enum logic [2:0] {
    VIC_ST_RUN   = 3'b001,
    VIC_ST_SLEEP = 3'b010,
    VIC_ST_ENTER = 3'b100
  } vic_state_t;

  typedef enum logic [1:0] {
    VIC_EDGE_OFF  = 2'b00,
    VIC_EDGE_RISE = 2'b01,
    VIC_EDGE_FALL = 2'b10,
    VIC_EDGE_BOTH = 2'b11
  } vic_edge_t;
endpackage
`default_nettype wire

// file: hw/vic_prio.sv
// Fixed priority pick among pending enabled requests
// Assumes index 0 owns the lowest vector address
`default_nettype none
module vic_prio #(
  parameter int N = 9
) (
  // Requests
  input  wire logic [N-1:0]         i_req,
  // Choice
  output logic                      o_any,
  output logic [$clog2(N)-1:0]      o_idx
);
  initial begin
    if (N < 2) $error("vic_prio needs two or more sources");
  end

  always_comb begin
    o_any = 1'b0;
    o_idx = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (i_req[k]) begin
        o_any = 1'b1;
        o_idx = k[$clog2(N)-1:0];
      end
    end
  end
endmodule // vic_prio

// file: hw/vic_ctrl.sv
// Vectored interrupt controller: flags, enables, priority, PC stack, wake
// Assumes core pulses i_boundary per instruction and i_return_from_interrupt on return
//
// How it works
// - Control byte two holds tick flags at bits 5 and 4, reset zero
// - Control byte two holds tick enables at bits 1 and 0, reset zero
// - Bits 7..6 and 3..2 of that byte read zero, writes ignored
// - Every source event sets its flag regardless of its enable
// - A flag causes a vector jump only with its enable set
// - Global enable low blocks every interrupt
// - Entry pushes next-instruction PC then loads the vector
// - Return instruction pops the saved PC to resume
// - Each source owns a distinct vector address
// - Taking any interrupt clears the global enable
// - Requests while blocked still set and keep flags
// - Full stack blocks acknowledging any request until popped
// - Simultaneous enabled requests resolve by fixed priority
// - A flag rising wakes from sleep; one already set does not
// - Pin flag sets on the edge type chosen by the select field
// - Servicing the pin interrupt clears its flag and global enable
// - Conversion flag sets on completion, cleared on service
// - Nonvolatile write flag sets at cycle end, cleared on service
// - Timer gives period and compare A requests, each separate
// - Serial flag sets on byte, address match or timeout in SPI/I2C
// - UART events raise serial request; UART status untouched
// - Edge field: 00 off, 01 rise, 10 fall, 11 both
// - Global enable is bit 0 of control byte zero, reset zero
`default_nettype none
`include "vic_regs.svh"
module vic_ctrl #(
  parameter int PC_W  = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_ce,
  // Avalon-MM slave
  input  wire logic [3:0]       i_avs_address,
  input  wire logic             i_avs_read,
  input  wire logic             i_avs_write,
  input  wire logic [31:0]      i_avs_writedata,
  input  wire logic [3:0]       i_avs_byteenable,
  output logic [31:0]           o_avs_readdata,
  output logic                  o_avs_waitrequest,
  output logic [1:0]            o_avs_response,
  // Event sources, one-cycle pulses except the pin, which is a level
  input  wire logic             i_pin_level,
  input  wire logic             i_conv_done,
  input  wire logic             i_nv_write_done,
  input  wire logic             i_period_match,
  input  wire logic             i_compare_a_match,
  input  wire logic             i_serial_event,
  input  wire logic             i_tick0,
  input  wire logic             i_tick1,
  // Core sequencer
  input  wire logic             i_boundary,
  input  wire logic [PC_W-1:0]  i_next_pc,
  input  wire logic             i_return_from_interrupt,
  input  wire logic             i_sleep_req,
  output logic                  o_take,
  output logic [PC_W-1:0]       o_pc,
  output logic                  o_pc_load,
  output logic                  o_stack_full,
  output logic                  o_sleeping,
  output logic                  o_wake
);
  localparam int NSRC = 9;
  localparam int SP_W = $clog2(DEPTH + 1);

  initial begin
    if (PC_W < 6 || DEPTH < 2) $error("vic_ctrl: bad PC_W or DEPTH");
  end

  // Source order doubles as priority: index 0 lowest vector
  // 0 pin,1 serial,2 conv,3 nv,4 period,5 cmpA,6 tick0,7 tick1,8 unused
  logic                 gie_reg;
  logic [NSRC-1:0]      flag_reg;
  logic [NSRC-1:0]      en_reg;
  logic [1:0]           edge_reg;
  logic                 pin_d_reg;
  logic [PC_W-1:0]      stack_reg [DEPTH];
  logic [SP_W-1:0]      sp_reg;
  logic [PC_W-1:0]      pc_reg;
  logic                 pc_load_reg;
  logic                 wake_reg;
  logic [31:0]          rdata_reg;
  logic                 ack_reg;
  logic [1:0]           resp_reg;
  vic_pkg::vic_state_t  st_reg;
  vic_pkg::vic_state_t  st_next;

  // Edge detect on the synchronous pin
  wire logic pin_rise = i_pin_level & ~pin_d_reg;
  wire logic pin_fall = ~i_pin_level & pin_d_reg;
  wire logic pin_hit  =
      (edge_reg == vic_pkg::VIC_EDGE_RISE && pin_rise) ||
      (edge_reg == vic_pkg::VIC_EDGE_FALL && pin_fall) ||
      (edge_reg == vic_pkg::VIC_EDGE_BOTH && (pin_rise | pin_fall));

  wire logic [NSRC-1:0] ev = {1'b0, i_tick1, i_tick0, i_compare_a_match,
                              i_period_match, i_nv_write_done,
                              i_conv_done, i_serial_event,
                              pin_hit};
  // Serial events come pre-merged; UART status is not ours

  // Priority choice among enabled flags
  wire logic [NSRC-1:0] pend = flag_reg & en_reg;
  wire logic            any_pend;
  wire logic [3:0]      pick;
  vic_prio #(.N(NSRC)) u_prio (
    .i_req (pend),
    .o_any (any_pend),
    .o_idx (pick)
  );

  wire logic full = (sp_reg == SP_W'(DEPTH));
  wire logic take = i_ce && any_pend && gie_reg && !full
                    && i_boundary
                    && st_reg == vic_pkg::VIC_ST_RUN;
  wire logic pop  = i_ce && i_return_from_interrupt && sp_reg != '0;
  wire logic [NSRC-1:0] svc_clr = take ? (NSRC'(1) << pick) : '0;

  // Vector table: base + index * step
  function automatic logic [PC_W-1:0] vec_of(input logic [3:0] idx);
    vec_of = PC_W'(`VIC_VEC_BASE) + PC_W'(`VIC_VEC_STEP) * PC_W'(idx);
  endfunction

  // Register decode
  wire logic sel_c0 = i_avs_address == `VIC_OFF_CTRL0;
  wire logic sel_c1 = i_avs_address == `VIC_OFF_CTRL1;
  wire logic sel_tb = i_avs_address == `VIC_OFF_TBCTRL;
  wire logic sel_eg = i_avs_address == `VIC_OFF_EDGE;
  wire logic sel_pc = i_avs_address == `VIC_OFF_PC;
  wire logic sel_st = i_avs_address == `VIC_OFF_STATUS;
  wire logic mapped = sel_c0 | sel_c1 | sel_tb | sel_eg | sel_pc | sel_st;
  wire logic req    = (i_avs_read | i_avs_write) && !ack_reg;
  wire logic wr     = i_ce && ack_reg && i_avs_write && i_avs_byteenable[0];
  wire logic [7:0] wb = i_avs_writedata[7:0];

  wire logic [7:0] c0_rd = {2'b00, flag_reg[1], flag_reg[0], 1'b0,
                            en_reg[1], en_reg[0], gie_reg};
  wire logic [7:0] c1_rd = {flag_reg[5], flag_reg[4], flag_reg[3],
                            flag_reg[2], en_reg[5], en_reg[4],
                            en_reg[3], en_reg[2]};
  wire logic [7:0] tb_rd = {2'b00, flag_reg[7], flag_reg[6], 2'b00,
                            en_reg[7], en_reg[6]};
  wire logic [31:0] rd_mux =
      sel_c0 ? {24'h000000, c0_rd} :
      sel_c1 ? {24'h000000, c1_rd} :
      sel_tb ? {24'h000000, tb_rd} :
      sel_eg ? {30'h0, edge_reg} :
      sel_pc ? 32'(pc_reg) :
      sel_st ? {24'h000000, 3'b000, st_reg, full, o_sleeping} :
      32'h00000000;

  // Software writes give the new flag and enable images
  logic [NSRC-1:0] sw_flag;
  logic [NSRC-1:0] sw_en;
  always_comb begin
    sw_flag = flag_reg;
    sw_en   = en_reg;
    if (wr && sel_c0) begin
      sw_flag[0] = wb[`VIC_BIT_PIN_F];
      sw_flag[1] = wb[`VIC_BIT_SER_F];
      sw_en[0]   = wb[`VIC_BIT_PIN_EN];
      sw_en[1]   = wb[`VIC_BIT_SER_EN];
    end else if (wr && sel_c1) begin
      sw_flag[5:2] = {wb[`VIC_BIT_CMPA_F], wb[`VIC_BIT_PER_F],
                      wb[`VIC_BIT_NV_F], wb[`VIC_BIT_CONV_F]};
      sw_en[5:2]   = {wb[`VIC_BIT_CMPA_EN], wb[`VIC_BIT_PER_EN],
                      wb[`VIC_BIT_NV_EN], wb[`VIC_BIT_CONV_EN]};
    end else if (wr && sel_tb) begin
      sw_flag[6] = wb[`VIC_BIT_TB0_F];
      sw_flag[7] = wb[`VIC_BIT_TB1_F];
      sw_en[6]   = wb[`VIC_BIT_TB0_EN];
      sw_en[7]   = wb[`VIC_BIT_TB1_EN];
    end
    sw_flag[8] = 1'b0;
    sw_en[8]   = 1'b0;
  end

  // Event set beats both software and service clear
  wire logic [NSRC-1:0] flag_next =
      (sw_flag & ~svc_clr) | ev;
  wire logic [NSRC-1:0] flag_rise = ev & ~flag_reg;

  // Global enable: service clears, software writes, return sets
  wire logic gie_next = take ? 1'b0 :
                        (wr && sel_c0) ? wb[`VIC_BIT_GIE] :
                        pop ? 1'b1 : gie_reg;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      vic_pkg::VIC_ST_RUN: begin
        if (take) st_next = vic_pkg::VIC_ST_ENTER;
        else if (i_sleep_req) st_next = vic_pkg::VIC_ST_SLEEP;
      end
      vic_pkg::VIC_ST_SLEEP: begin
        if (|flag_rise) st_next = vic_pkg::VIC_ST_RUN;
      end
      vic_pkg::VIC_ST_ENTER: st_next = vic_pkg::VIC_ST_RUN;
      default: st_next = vic_pkg::VIC_ST_RUN;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      flag_reg  <= '0;
      en_reg    <= '0;
      gie_reg   <= 1'b0;
      edge_reg  <= 2'b00;
      pin_d_reg <= 1'b0;
      st_reg    <= vic_pkg::VIC_ST_RUN;
    end else if (i_ce) begin
      flag_reg  <= flag_next;
      en_reg    <= sw_en;
      gie_reg   <= gie_next;
      pin_d_reg <= i_pin_level;
      st_reg    <= st_next;
      if (wr && sel_eg) edge_reg <= wb[1:0];
    end
  end

  // Return stack of program counters
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sp_reg      <= '0;
      pc_reg      <= '0;
      pc_load_reg <= 1'b0;
    end else if (i_ce) begin
      pc_load_reg <= take | pop;
      if (take) begin
        stack_reg[sp_reg[$clog2(DEPTH)-1:0]] <= i_next_pc;
        sp_reg <= sp_reg + SP_W'(1);
        pc_reg <= vec_of(pick);
      end else if (pop) begin
        sp_reg <= sp_reg - SP_W'(1);
        pc_reg <= stack_reg[$clog2(DEPTH)'(sp_reg - SP_W'(1))];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wake_reg <= 1'b0;
    end else if (i_ce) begin
      wake_reg <= (st_reg == vic_pkg::VIC_ST_SLEEP) && |flag_rise;
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
      resp_reg  <= 2'b00;
    end else if (i_ce) begin
      ack_reg   <= req;
      rdata_reg <= rd_mux;
      resp_reg  <= mapped ? 2'b00 : 2'b11;
    end
  end

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~(ack_reg & i_ce);
  assign o_avs_readdata    = rdata_reg;
  assign o_avs_response    = resp_reg;
  assign o_take            = take;
  assign o_pc              = pc_reg;
  assign o_pc_load         = pc_load_reg;
  assign o_stack_full      = full;
  assign o_sleeping        = st_reg == vic_pkg::VIC_ST_SLEEP;
  assign o_wake            = wake_reg;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst || !i_ce);

  sequence s_taken; take; endsequence
  sequence s_loaded; o_pc_load && o_pc == vec_of($past(pick)); endsequence

  chk_vector_load: assert property (s_taken |=> s_loaded)
    else $error("vector not loaded after entry");
  chk_gie_cleared: assert property (take |=> !gie_reg)
    else $error("global enable still set after entry");
  chk_gie_blocks: assert property (!gie_reg |-> !take)
    else $error("entry with global enable low");
  chk_full_blocks: assert property (full |-> !take)
    else $error("entry with full stack");
  chk_event_sets: assert property (ev[2] |=> flag_reg[2])
    else $error("conversion event lost");
  chk_disabled_src: assert property (take |-> en_reg[pick])
    else $error("disabled source taken");
  chk_svc_clear: assert property (
      take && !ev[pick] |=> !flag_reg[$past(pick)])
    else $error("serviced flag not cleared");
  chk_boundary_only: assert property (take |-> i_boundary)
    else $error("entry off instruction boundary");
  chk_sleep_wake: assert property (
      o_sleeping && |flag_rise |=> o_wake ##1 !o_wake)
    else $error("wake pulse wrong");
  chk_tb_reserved: assert property (
      ack_reg && $past(sel_tb) |->
      (o_avs_readdata & ~32'(`VIC_TBCTRL_MASK)) == 32'h00000000)
    else $error("reserved tick bits nonzero");
endmodule // vic_ctrl
`default_nettype wire

// file: verification/vic_core_model.sv
// Core sequencer stand-in: instruction boundary every fourth cycle
// Assumes the controller's sleeping level halts instruction issue
`default_nettype none
module vic_core_model (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  // Controller state
  input  wire logic i_sleeping,
  // Sequencer
  output logic      o_boundary
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  // No instruction ends while asleep
  assign o_boundary = (cnt_reg == 2'h3) && !i_sleeping;
endmodule // vic_core_model
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench of the vectored interrupt controller
// Assumes vic_ctrl with default parameters and a 10 MHz clock
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic        pin = 1'b0, return_from_interrupt = 1'b0, slp = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, seed = 32'h2edc;
  logic [7:0]  ev = 8'h00;
  logic [11:0] npc = 12'h000;
  wire logic [31:0] rdata;
  wire logic [11:0] pc;
  wire logic [1:0]  resp;
  wire logic        wait_req, pc_load, full, sleeping, wake, bnd, took;
  int          n_errors = 0, n_tests = 0;
  logic [9:0]  exp_rd[$];
  logic [11:0] exp_pc[$];

  initial begin
    forever #50 clk = ~clk;
  end

  vic_core_model vic_core_model_inst (.i_mclk(clk), .i_sys_rst(rst),
    .i_sleeping(sleeping), .o_boundary(bnd));
  vic_ctrl vic_ctrl_inst (.i_mclk(clk), .i_sys_rst(rst), .i_ce(1'b1),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
    .o_avs_response(resp), .i_pin_level(pin), .i_conv_done(ev[2]),
    .i_nv_write_done(ev[3]), .i_period_match(ev[4]),
    .i_compare_a_match(ev[5]), .i_serial_event(ev[1]), .i_tick0(ev[6]),
    .i_tick1(ev[7]), .i_boundary(bnd), .i_next_pc(npc), .i_return_from_interrupt(return_from_interrupt),
    .i_sleep_req(slp), .o_take(took), .o_pc(pc), .o_pc_load(pc_load),
    .o_stack_full(full), .o_sleeping(sleeping), .o_wake(wake));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic ok, input string what);
    n_tests++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wait_req !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                        input logic [1:0] r);
    exp_rd.push_back({r, e});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic pulse_ev(input int k);
    @(posedge clk);
    if (k == 0) pin <= ~pin;
    else ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 8'h00;
  endtask

  task automatic do_return_from_interrupt();
    @(posedge clk);
    return_from_interrupt <= 1'b1;
    @(posedge clk);
    return_from_interrupt <= 1'b0;
  endtask

  // Results are matched in order against the notes queued by the driver
  always @(negedge clk) begin
    if (rd && wait_req === 1'b0) begin
      if (exp_rd.size() == 0) chk(1'b0, "unexpected read");
      else chk({resp, rdata} === {exp_rd[0][9:8], 24'h0, exp_rd[0][7:0]},
               "read data or response");
      if (exp_rd.size() != 0) void'(exp_rd.pop_front());
    end
    if (pc_load === 1'b1) begin
      if (exp_pc.size() == 0) chk(1'b0, "unexpected pc load");
      else chk(pc === exp_pc.pop_front(), "pc load value");
    end
    if (took === 1'b1) chk(bnd === 1'b1, "entry off boundary");
  end

  initial begin
    #1000000;
    n_errors++;
    test_done();
  end

  initial begin
    int a, b;
    logic seen;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(4'h2, 8'h00, 2'b00);
    rd_chk(4'h0, 8'h00, 2'b00);
    bus(1'b1, 4'h2, 8'hff);
    rd_chk(4'h2, 8'h33, 2'b00);
    rd_chk(4'h6, 8'h00, 2'b11);
    bus(1'b1, 4'h2, 8'h02);
    pulse_ev(7);
    repeat (12) @(posedge clk);
    rd_chk(4'h2, 8'h22, 2'b00);
    bus(1'b1, 4'h2, 8'h00);
    bus(1'b1, 4'h0, 8'h01);
    pulse_ev(7);
    repeat (12) @(posedge clk);
    rd_chk(4'h2, 8'h20, 2'b00);
    @(posedge clk) slp <= 1'b1;
    @(posedge clk) slp <= 1'b0;
    repeat (2) @(posedge clk);
    pulse_ev(7);
    repeat (3) @(negedge clk);
    chk(sleeping === 1'b1 && wake === 1'b0, "woke on old flag");
    pulse_ev(6);
    seen = 1'b0;
    repeat (4) begin
      @(negedge clk);
      if (wake === 1'b1) seen = 1'b1;
    end
    chk(seen === 1'b1 && sleeping === 1'b0, "no wake");
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b1, 4'h2, 8'h00);
    bus(1'b1, 4'h3, 8'h03);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      npc <= seed[11:0];
      a = (k < 2) ? 0 : ((k < 6) ? 1 : 2);
      b = (k < 2) ? k + 1 : ((k < 6) ? k - 2 : k - 6);
      bus(1'b1, a[3:0], 8'h01 << b);
      pulse_ev(k);
      exp_pc.push_back(12'(4 * (k + 1)));
      exp_pc.push_back(seed[11:0]);
      // Flag bit rides along so the write keeps the pending request
      bus(1'b1, 4'h0, 8'h01 | ((a == 0) ? (8'h09 << b) : 8'h00));
      repeat (10) @(posedge clk);
      rd_chk(a[3:0], 8'h01 << b, 2'b00);
      do_return_from_interrupt();
      repeat (4) @(posedge clk);
      bus(1'b1, a[3:0], 8'h00);
      bus(1'b1, 4'h0, 8'h00);
    end
    bus(1'b1, 4'h1, 8'h03);
    @(posedge clk) ev <= 8'h0c;
    @(posedge clk) ev <= 8'h00;
    exp_pc.push_back(12'h00c);
    exp_pc.push_back(npc);
    exp_pc.push_back(12'h010);
    exp_pc.push_back(npc);
    bus(1'b1, 4'h0, 8'h01);
    repeat (10) @(posedge clk);
    do_return_from_interrupt();
    repeat (10) @(posedge clk);
    do_return_from_interrupt();
    repeat (4) @(posedge clk);
    bus(1'b1, 4'h1, 8'h00);
    bus(1'b1, 4'h2, 8'h01);
    repeat (8) begin
      exp_pc.push_back(12'h01c);
      pulse_ev(6);
      bus(1'b1, 4'h0, 8'h01);
      repeat (10) @(posedge clk);
    end
    chk(full === 1'b1, "stack not full");
    // Refused while full: an extra load would find the queue empty
    pulse_ev(6);
    bus(1'b1, 4'h0, 8'h01);
    repeat (12) @(posedge clk);
    bus(1'b1, 4'h2, 8'h00);
    repeat (8) begin
      exp_pc.push_back(npc);
      do_return_from_interrupt();
      repeat (3) @(posedge clk);
    end
    bus(1'b1, 4'h0, 8'h00);
    @(posedge clk) pin <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 4'h3, c[7:0]);
      bus(1'b1, 4'h0, 8'h00);
      @(posedge clk) pin <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(4'h0, {3'b000, c[0], 4'h0}, 2'b00);
      bus(1'b1, 4'h0, 8'h00);
      @(posedge clk) pin <= 1'b0;
      repeat (3) @(posedge clk);
      rd_chk(4'h0, {3'b000, c[1], 4'h0}, 2'b00);
    end
    repeat (4) @(posedge clk);
    chk(exp_pc.size() == 0 && exp_rd.size() == 0, "results missing");
    test_done();
  end
endmodule // tb
`default_nettype wire
